/* design/instrument_power_sleep_supervisor.sv */
// Power, sleep and watchdog keep-alive supervisor for the instrument.
// Assumes an interval tick pulse, a port write bus and command bus discretes.
module instrument_power_sleep_supervisor
    import pwr_sleep_pkg::*;
#(
    parameter int LIMIT_W = 16
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic TICK,
    input wire logic PORT_WR,
    input wire logic PORT_RD,
    input wire logic [7:0] PORT_ADDR,
    input wire logic [7:0] PORT_WDATA,
    output logic [7:0] PORT_RDATA,
    input wire logic CMD_VALID,
    input wire logic [2:0] CMD_ASSEMBLY,
    input wire logic CMD_ON,
    input wire logic KEEPALIVE,
    input wire logic SLEEP_DISCRETE,
    input wire logic MAINT_DISCRETE,
    output logic [1:0] SLEEP_BITS,
    output logic [1:0] LOW_RATE_CLK_SEL,
    output logic [1:0] HIGH_RATE_CLK_SEL,
    output logic SLEEP_LINE,
    output logic SCHED_HALT,
    output logic SLEEP_ERROR_FLAG,
    output logic HFR_POWER,
    output logic ANALOG_POWER,
    output logic CONVERTER_POWER,
    output logic PROBE_DIGITAL_POWER,
    output logic PROBE_ANALOG_POWER,
    output logic MAINT_MODE,
    output logic TIME_UPDATE,
    output logic WDOG_REFRESH,
    output logic WDOG_TRIP
);
    // -----------------------------------------------------------------
    // Functions
    // -----------------------------------------------------------------
    // Low-rate processor clock for a sleep pattern
    function automatic logic [1:0] low_rate_of(input logic [1:0] p);
        low_rate_of = (p == SLEEP_FULL || p == SLEEP_SCIENCE) ? RATE_FULL : RATE_HALF;
    endfunction : low_rate_of
    // High-rate processor clock for a sleep pattern
    function automatic logic [1:0] high_rate_of(input logic [1:0] p);
        high_rate_of = (p == SLEEP_FULL || p == SLEEP_ERROR) ? RATE_FULL : RATE_SLOW;
    endfunction : high_rate_of

    // -----------------------------------------------------------------
    // Discrete synchronisers (three stages, second and third agree)
    // -----------------------------------------------------------------
    logic [2:0] sleep_sync_q; // Sleep discrete stages
    logic [2:0] maint_sync_q; // Maintenance discrete stages
    logic sleep_disc_q; // Filtered sleep discrete
    logic maint_disc_q; // Filtered maintenance discrete

    // Reset gives the sleep level: no false wake
    // Sampled every cycle, whatever the power state
    always_ff @(posedge CLK) begin
        if (SRST) begin
            sleep_sync_q <= 3'h0;
            maint_sync_q <= 3'h0;
            sleep_disc_q <= 1'b0;
            maint_disc_q <= 1'b0;
        end else begin
            sleep_sync_q <= {sleep_sync_q[1:0], SLEEP_DISCRETE};
            maint_sync_q <= {maint_sync_q[1:0], MAINT_DISCRETE};
            if (sleep_sync_q[1] == sleep_sync_q[2]) begin
                sleep_disc_q <= sleep_sync_q[2];
            end
            if (maint_sync_q[1] == maint_sync_q[2]) begin
                maint_disc_q <= maint_sync_q[2];
            end
        end
    end

    // -----------------------------------------------------------------
    // Register file
    // -----------------------------------------------------------------
    logic [7:0] probe_port_q; // Probe power port
    logic [7:0] conv_port_q; // Converter power port
    logic [7:0] time_en_q; // Time-distribution enable
    logic [15:0] wdog_limit_q; // Watchdog expiry limit
    logic [7:0] policy_q; // Watchdog refresh policy
    logic hfr_q; // HFR power switch
    logic analog_q; // Analog power switch
    logic lprobe_q; // Probe analog switch
    logic asleep_q; // Secondary sleep state

    // Decoded write strobes
    wire wr_probe = PORT_WR && PORT_ADDR == PROBE_POWER_OFS;
    wire wr_conv = PORT_WR && PORT_ADDR == CONVERTER_POWER_OFS;
    wire wr_time = PORT_WR && PORT_ADDR == TIME_DIST_ENABLE_OFS;
    wire wr_lim_lo = PORT_WR && PORT_ADDR == WDOG_LIMIT_LO_OFS;
    wire wr_lim_hi = PORT_WR && PORT_ADDR == WDOG_LIMIT_HI_OFS;
    wire wr_policy = PORT_WR && PORT_ADDR == WDOG_POLICY_OFS;
    // Switch commands honoured only when awake
    // Commands with the discrete low are dropped
    wire cmd_ok = CMD_VALID && sleep_disc_q;
    wire cmd_sw = cmd_ok && !asleep_q;
    wire low_power = !sleep_disc_q || asleep_q;

    // Port registers; other values are stored but only bit 0 switches
    // Limit bytes act as written; set low byte first
    // while the watchdog is in every-tick mode
    always_ff @(posedge CLK) begin
        if (SRST) begin
            probe_port_q <= POWER_OFF_VAL;
            conv_port_q <= POWER_OFF_VAL;
            time_en_q <= TIME_DIST_ENABLE_RST;
            wdog_limit_q <= WDOG_LIMIT_RST;
            policy_q <= WDOG_POLICY_RST;
        end else begin
            if (low_power) begin
                probe_port_q <= POWER_OFF_VAL;
                conv_port_q <= POWER_OFF_VAL;
            end else begin
                if (wr_probe) begin
                    probe_port_q <= PORT_WDATA;
                end
                if (wr_conv) begin
                    conv_port_q <= PORT_WDATA;
                end
            end
            if (wr_time) begin
                time_en_q <= PORT_WDATA;
            end
            if (wr_lim_lo) begin
                wdog_limit_q[7:0] <= PORT_WDATA;
            end
            if (wr_lim_hi) begin
                wdog_limit_q[15:8] <= PORT_WDATA;
            end
            if (wr_policy) begin
                policy_q <= PORT_WDATA;
            end
        end
    end

    // Supply switches and the secondary sleep state
    // Leaving sleep turns no supply on by itself
    always_ff @(posedge CLK) begin
        if (SRST) begin
            hfr_q <= 1'b0;
            analog_q <= 1'b0;
            lprobe_q <= 1'b0;
            asleep_q <= 1'b1;
        end else if (!sleep_disc_q) begin
            hfr_q <= 1'b0;
            analog_q <= 1'b0;
            lprobe_q <= 1'b0;
            asleep_q <= 1'b1;
        end else if (cmd_ok) begin
            case (CMD_ASSEMBLY)
                ASM_HFR: begin
                    hfr_q <= cmd_sw ? CMD_ON : hfr_q;
                    asleep_q <= 1'b0; // Any switch command (HFR, analog, probe) leaves sleep
                end
                ASM_ANALOG: begin
                    analog_q <= cmd_sw ? CMD_ON : analog_q;
                    asleep_q <= 1'b0;
                end
                ASM_LPROBE: begin
                    lprobe_q <= cmd_sw ? CMD_ON : lprobe_q;
                    asleep_q <= 1'b0;
                end
                ASM_SLEEP: begin
                    if (!CMD_ON) begin
                        hfr_q <= 1'b0;
                        analog_q <= 1'b0;
                        lprobe_q <= 1'b0;
                        asleep_q <= 1'b1;
                    end else begin
                        asleep_q <= 1'b0; // Switches left alone
                    end
                end
                default: begin
                    asleep_q <= asleep_q;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Pause sequencer
    // -----------------------------------------------------------------
    pause_state_t pstate_q; // Sequencer state
    logic [2:0] ptick_q; // Ticks while line active
    logic sleep_line_q; // Sleep line to high-rate side

    // A pause during a pause is dropped
    wire pause_req = cmd_ok && CMD_ASSEMBLY == ASM_PAUSE;

    // Line held for PAUSE_TICKS ticks, giving one to two tick periods
    always_ff @(posedge CLK) begin
        if (SRST) begin
            pstate_q <= PS_IDLE;
            ptick_q <= 3'h0;
            sleep_line_q <= 1'b0;
        end else begin
            case (pstate_q)
                PS_IDLE: begin
                    if (pause_req) begin
                        pstate_q <= PS_DRIVE;
                        sleep_line_q <= 1'b1;
                        ptick_q <= 3'h0;
                    end
                end
                PS_DRIVE: begin
                    if (TICK) begin
                        ptick_q <= ptick_q + 3'h1;
                    end
                    // Released well short of POWER_DROP_TICKS
                    if (TICK && ptick_q + 3'h1 >= PAUSE_TICKS) begin
                        pstate_q <= PS_HOLD;
                        sleep_line_q <= 1'b0;
                    end
                end
                // One idle cycle before a new pause
                PS_HOLD: begin
                    pstate_q <= PS_IDLE;
                end
                default: begin
                    pstate_q <= PS_IDLE;
                    sleep_line_q <= 1'b0;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Sleep bits and clock rates
    // -----------------------------------------------------------------
    // When awake both bits move together with the line, never a mixed pattern
    // Pattern 10 cannot be formed; flag guards edits
    wire [1:0] sleep_pat = sleep_line_q ? SLEEP_SCIENCE :
                           (low_power ? SLEEP_ROM : SLEEP_FULL);
    assign SLEEP_BITS = sleep_pat;
    assign LOW_RATE_CLK_SEL = low_rate_of(sleep_pat);
    assign HIGH_RATE_CLK_SEL = high_rate_of(sleep_pat);
    assign SLEEP_ERROR_FLAG = sleep_pat == SLEEP_ERROR;
    assign SLEEP_LINE = sleep_line_q;
    assign SCHED_HALT = sleep_line_q || low_power;

    // Supply outputs; a pause pulse also pulses the probe supplies
    assign HFR_POWER = hfr_q;
    assign ANALOG_POWER = analog_q;
    assign CONVERTER_POWER = conv_port_q[0];
    assign PROBE_DIGITAL_POWER = probe_port_q[0] && !sleep_line_q;
    assign PROBE_ANALOG_POWER = lprobe_q && PROBE_DIGITAL_POWER;
    assign MAINT_MODE = maint_disc_q && sleep_disc_q;

    // -----------------------------------------------------------------
    // Interval tick counter, time updates, watchdog
    // -----------------------------------------------------------------
    logic [11:0] tick_cnt_q; // Free interval tick counter
    logic [LIMIT_W-1:0] quiet_q; // Ticks since last keep-alive
    logic tupd_q; // Time update pulse
    logic refresh_q; // Watchdog refresh pulse
    logic trip_q; // Limit reached

    // Enable is sampled at the due tick itself
    wire tupd_due = TICK && tick_cnt_q == TIME_UPDATE_TICKS - 12'h1;
    wire restrictive = policy_q == POLICY_KEEPALIVE;
    wire quiet_out = quiet_q >= wdog_limit_q[LIMIT_W-1:0];

    // Counts and pulses; a keep-alive on a tick still wins
    // Quiet count saturates so a trip never wraps
    // Trip holds until a keep-alive, a write of a policy other than POLICY_KEEPALIVE, or a higher limit
    always_ff @(posedge CLK) begin
        if (SRST) begin
            tick_cnt_q <= 12'h0;
            quiet_q <= '0;
            tupd_q <= 1'b0;
            refresh_q <= 1'b0;
            trip_q <= 1'b0;
        end else begin
            if (TICK) begin
                tick_cnt_q <= tupd_due ? 12'h0 : tick_cnt_q + 12'h1;
            end
            tupd_q <= tupd_due && time_en_q != 8'h00;
            if (KEEPALIVE) begin
                quiet_q <= '0;
            end else if (TICK && !quiet_out) begin
                quiet_q <= quiet_q + 1'b1;
            end
            if (restrictive) begin
                refresh_q <= KEEPALIVE;
            end else begin
                refresh_q <= TICK;
            end
            trip_q <= restrictive && quiet_out;
        end
    end
    assign TIME_UPDATE = tupd_q;
    assign WDOG_REFRESH = refresh_q;
    assign WDOG_TRIP = trip_q;

    // -----------------------------------------------------------------
    // Read data, registered; unmapped reads return zero
    // -----------------------------------------------------------------
    logic [7:0] rdata_q;
    wire [7:0] status = {3'h0, SLEEP_ERROR_FLAG, asleep_q, sleep_line_q, sleep_pat};
    // Reads have no side effects; poll freely
    wire [7:0] rd_mux =
        PORT_ADDR == PROBE_POWER_OFS ? probe_port_q :
        PORT_ADDR == CONVERTER_POWER_OFS ? conv_port_q :
        PORT_ADDR == TIME_DIST_ENABLE_OFS ? time_en_q :
        PORT_ADDR == WDOG_LIMIT_LO_OFS ? wdog_limit_q[7:0] :
        PORT_ADDR == WDOG_LIMIT_HI_OFS ? wdog_limit_q[15:8] :
        PORT_ADDR == WDOG_POLICY_OFS ? policy_q :
        PORT_ADDR == STATUS_OFS ? status : 8'h00;
    always_ff @(posedge CLK) begin
        if (SRST) begin
            rdata_q <= 8'h00;
        end else if (PORT_RD) begin
            rdata_q <= rd_mux;
        end
    end
    assign PORT_RDATA = rdata_q;
endmodule : instrument_power_sleep_supervisor

/* design/pwr_sleep_pkg.sv */
// Package: constants for the instrument power and sleep supervisor.
// Assumes a single 250 MHz clock and an interval tick strobe from elsewhere.
package pwr_sleep_pkg;
    // -----------------------------------------------------------------
    // Port offsets (byte addresses on the internal port bus)
    // -----------------------------------------------------------------
    localparam logic [7:0] PROBE_POWER_OFS = 8'h03;
    localparam logic [7:0] CONVERTER_POWER_OFS = 8'h40;
    localparam logic [7:0] TIME_DIST_ENABLE_OFS = 8'h60;
    localparam logic [7:0] WDOG_LIMIT_LO_OFS = 8'h62;
    localparam logic [7:0] WDOG_LIMIT_HI_OFS = 8'h63;
    localparam logic [7:0] WDOG_POLICY_OFS = 8'h6E;
    localparam logic [7:0] STATUS_OFS = 8'hF0;
    // -----------------------------------------------------------------
    // Reset values and port values
    // -----------------------------------------------------------------
    localparam logic [7:0] POWER_OFF_VAL = 8'h00;
    localparam logic [7:0] POWER_ON_VAL = 8'h01;
    localparam logic [7:0] TIME_DIST_ENABLE_RST = 8'hFF;
    localparam logic [15:0] WDOG_LIMIT_RST = 16'h12C0;
    localparam logic [7:0] POLICY_EVERY_TICK = 8'h00;
    localparam logic [7:0] POLICY_KEEPALIVE = 8'hFF;
    localparam logic [7:0] WDOG_POLICY_RST = 8'h00;
    // -----------------------------------------------------------------
    // Timing counts in interval ticks
    // -----------------------------------------------------------------
    localparam logic [2:0] PAUSE_TICKS = 3'h2;
    localparam logic [2:0] POWER_DROP_TICKS = 3'h4;
    localparam logic [11:0] TIME_UPDATE_TICKS = 12'h800;
    // -----------------------------------------------------------------
    // Sleep control patterns {hi, lo}
    // -----------------------------------------------------------------
    localparam logic [1:0] SLEEP_FULL = 2'h0;
    localparam logic [1:0] SLEEP_ROM = 2'h1;
    localparam logic [1:0] SLEEP_ERROR = 2'h2;
    localparam logic [1:0] SLEEP_SCIENCE = 2'h3;
    // Clock-rate codes: 0 full 1.5 MHz, 1 half 750 kHz, 2 slow 287 kHz
    localparam logic [1:0] RATE_FULL = 2'h0;
    localparam logic [1:0] RATE_HALF = 2'h1;
    localparam logic [1:0] RATE_SLOW = 2'h2;
    // Power command assemblies
    localparam logic [2:0] ASM_HFR = 3'h0;
    localparam logic [2:0] ASM_ANALOG = 3'h1;
    localparam logic [2:0] ASM_LPROBE = 3'h2;
    localparam logic [2:0] ASM_SLEEP = 3'h3;
    localparam logic [2:0] ASM_PAUSE = 3'h4;
    // Pause sequencer states, Gray from PS_IDLE to PS_HOLD; the return from PS_HOLD to PS_IDLE flips both bits
    typedef enum logic [1:0] {
        PS_IDLE = 2'b00,
        PS_DRIVE = 2'b01,
        PS_HOLD = 2'b11
    } pause_state_t;
endpackage : pwr_sleep_pkg

/* tb/pwr_sleep_properties.sv */
// Checker for the power and sleep supervisor ports.
// Assumes one clock domain; bound to every supervisor instance.
module pwr_sleep_checker
    import pwr_sleep_pkg::*;
(
    input wire logic CLK,
    input wire logic SRST,
    input wire logic TICK,
    input wire logic PORT_WR,
    input wire logic [7:0] PORT_ADDR,
    input wire logic [7:0] PORT_WDATA,
    input wire logic CMD_VALID,
    input wire logic [2:0] CMD_ASSEMBLY,
    input wire logic KEEPALIVE,
    input wire logic SLEEP_DISCRETE,
    input wire logic [1:0] SLEEP_BITS,
    input wire logic [1:0] LOW_RATE_CLK_SEL,
    input wire logic [1:0] HIGH_RATE_CLK_SEL,
    input wire logic SLEEP_LINE,
    input wire logic SCHED_HALT,
    input wire logic SLEEP_ERROR_FLAG,
    input wire logic HFR_POWER,
    input wire logic ANALOG_POWER,
    input wire logic CONVERTER_POWER,
    input wire logic PROBE_DIGITAL_POWER,
    input wire logic PROBE_ANALOG_POWER,
    input wire logic MAINT_MODE,
    input wire logic WDOG_REFRESH
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    logic [7:0] policy_q; // Shadow of the refresh policy byte
    logic [2:0] pause_ticks_q; // Ticks seen while the sleep line is up
    // Policy shadow follows every write to its port
    always_ff @(posedge CLK) begin
        if (SRST) begin
            policy_q <= WDOG_POLICY_RST;
        end else if (PORT_WR && PORT_ADDR == WDOG_POLICY_OFS) begin
            policy_q <= PORT_WDATA;
        end
    end
    // Saturates so a stuck line cannot wrap back into range
    always_ff @(posedge CLK) begin
        if (SRST || !SLEEP_LINE) begin
            pause_ticks_q <= 3'h0;
        end else if (TICK && pause_ticks_q != 3'h7) begin
            pause_ticks_q <= pause_ticks_q + 3'h1;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    // ----------------------------------------
    // Sequences and properties
    // ----------------------------------------
    // Discrete settled high, awake, then a pause request
    sequence awake_pause_req;
        SLEEP_DISCRETE [*6] ##0 (CMD_VALID && CMD_ASSEMBLY == ASM_PAUSE
            && SLEEP_BITS == SLEEP_FULL);
    endsequence
    // Long enough to pass the discrete synchroniser
    sequence discrete_low;
        !SLEEP_DISCRETE [*8];
    endsequence
    a_rate_full: assert property (SLEEP_BITS == SLEEP_FULL |->
        LOW_RATE_CLK_SEL == RATE_FULL && HIGH_RATE_CLK_SEL == RATE_FULL)
        else $error("rates wrong for full pattern");
    a_rate_rom: assert property (SLEEP_BITS == SLEEP_ROM |->
        LOW_RATE_CLK_SEL == RATE_HALF && HIGH_RATE_CLK_SEL == RATE_SLOW)
        else $error("rates wrong for rom sleep pattern");
    a_rate_science: assert property (SLEEP_BITS == SLEEP_SCIENCE |->
        LOW_RATE_CLK_SEL == RATE_FULL && HIGH_RATE_CLK_SEL == RATE_SLOW)
        else $error("rates wrong for science sleep pattern");
    a_pause_start: assert property (awake_pause_req |=>
        SLEEP_LINE && SLEEP_BITS == SLEEP_SCIENCE)
        else $error("pause did not raise line and both bits");
    a_pause_max: assert property (SLEEP_LINE |-> pause_ticks_q <= 3'h2)
        else $error("sleep line held past two ticks");
    a_pause_min: assert property ($fell(SLEEP_LINE) && !$past(SRST) |->
        pause_ticks_q != 3'h0)
        else $error("sleep line released before one tick");
    a_halt_now: assert property (SLEEP_LINE |-> SCHED_HALT)
        else $error("scheduling not halted with sleep line");
    a_probe_gated: assert property (SLEEP_LINE |-> !PROBE_DIGITAL_POWER)
        else $error("probe digital power on during sleep line");
    a_analog_follows: assert property (!PROBE_DIGITAL_POWER |->
        !PROBE_ANALOG_POWER)
        else $error("probe analog power without digital power");
    a_pause_keeps: assert property (SLEEP_LINE && $past(SLEEP_LINE) &&
        !$past(CMD_VALID) && !$past(PORT_WR) |->
        $stable({HFR_POWER, ANALOG_POWER, CONVERTER_POWER}))
        else $error("power switch moved during pause");
    a_no_mixed: assert property (SLEEP_BITS != SLEEP_ERROR &&
        SLEEP_ERROR_FLAG == 1'h0)
        else $error("error sleep pattern produced");
    a_tick_refresh: assert property (TICK && policy_q != POLICY_KEEPALIVE |=>
        WDOG_REFRESH)
        else $error("tick did not refresh watchdog");
    a_keep_refresh: assert property (policy_q == POLICY_KEEPALIVE |=>
        WDOG_REFRESH == $past(KEEPALIVE))
        else $error("refresh not tied to keep-alive");
    a_sleep_low: assert property (discrete_low |-> !HFR_POWER &&
        !ANALOG_POWER && !CONVERTER_POWER && !PROBE_DIGITAL_POWER
        && !MAINT_MODE && SLEEP_BITS == SLEEP_ROM)
        else $error("power or maintenance on with discrete clear");
endmodule : pwr_sleep_checker

bind instrument_power_sleep_supervisor pwr_sleep_checker i_chk (.*);

/* tb/cmd_bus_model.sv */
// Model of the command bus controller: power commands and discretes.
// Assumes the bench calls its tasks from one process only.
module cmd_bus_model
    import pwr_sleep_pkg::*;
(
    input wire logic CLK,
    output logic CMD_VALID,
    output logic [2:0] CMD_ASSEMBLY,
    output logic CMD_ON,
    output logic SLEEP_DISCRETE,
    output logic MAINT_DISCRETE
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle levels from time zero
    initial begin
        CMD_VALID = 1'h0;
        CMD_ASSEMBLY = 3'h0;
        CMD_ON = 1'h0;
        SLEEP_DISCRETE = 1'h0;
        MAINT_DISCRETE = 1'h0;
    end
    // One-cycle command; fields flip afterwards so stale values never pass
    task automatic send(input logic [2:0] asm, input logic on);
        @(posedge CLK);
        CMD_VALID <= 1'h1;
        CMD_ASSEMBLY <= asm;
        CMD_ON <= on;
        @(posedge CLK);
        CMD_VALID <= 1'h0;
        CMD_ASSEMBLY <= ~asm;
        CMD_ON <= ~on;
        repeat (4) @(posedge CLK); // Settling gap after every command
    endtask : send
    // Discretes change whatever the power state
    task automatic discretes(input logic slp, input logic mnt);
        @(posedge CLK);
        SLEEP_DISCRETE <= slp;
        MAINT_DISCRETE <= mnt;
        repeat (8) @(posedge CLK);
    endtask : discretes
endmodule : cmd_bus_model

/* tb/test_instrument_power_sleep_supervisor.sv */
// Self-checking bench for the power and sleep supervisor.
// Assumes the checker is bound in and the bus model drives commands.
module test_instrument_power_sleep_supervisor
    import pwr_sleep_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 1'h0, SRST = 1'h1, TICK = 1'h0, KEEPALIVE = 1'h0;
    logic PORT_WR = 1'h0, PORT_RD = 1'h0;
    logic [7:0] PORT_ADDR = 8'h00, PORT_WDATA = 8'h00, PORT_RDATA, en_q = 8'hFF;
    logic CMD_VALID, CMD_ON, SLEEP_DISCRETE, MAINT_DISCRETE;
    logic [2:0] CMD_ASSEMBLY;
    logic [1:0] SLEEP_BITS, LOW_RATE_CLK_SEL, HIGH_RATE_CLK_SEL;
    logic SLEEP_LINE, SCHED_HALT, SLEEP_ERROR_FLAG, HFR_POWER, ANALOG_POWER;
    logic CONVERTER_POWER, PROBE_DIGITAL_POWER, PROBE_ANALOG_POWER, MAINT_MODE;
    logic TIME_UPDATE, WDOG_REFRESH, WDOG_TRIP;
    logic [15:0] tu_seen = 16'h0, tu_exp = 16'h0;
    logic [31:0] rnd = 32'hA30B1BD9;
    int err_count = 0, checks_done = 0, tick_n = 0, lim;
    wire logic [15:0] obs = {1'h0, LOW_RATE_CLK_SEL, HIGH_RATE_CLK_SEL, SLEEP_BITS,
        SLEEP_LINE, SCHED_HALT, HFR_POWER, ANALOG_POWER, CONVERTER_POWER,
        PROBE_DIGITAL_POWER, PROBE_ANALOG_POWER, MAINT_MODE, WDOG_TRIP};
    instrument_power_sleep_supervisor i_dut (.*);
    cmd_bus_model i_bus (.*);
    always #2 CLK = ~CLK;
    // ----------------------------------------
    // Expectation helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // sw is {hfr, analog, lprobe, converter}; prb is the probe port bit
    function automatic logic [15:0] want(input logic [1:0] b, input logic [3:0] sw,
        input logic prb, input logic mnt, input logic trip);
        logic ln;
        ln = (b == 2'h3);
        return {1'h0, (b[1] ^ b[0]) ? 2'h1 : 2'h0, b[0] ? 2'h2 : 2'h0, b, ln, b != 2'h0,
            sw[3], sw[2], sw[0], prb & !ln, prb & !ln & sw[1], mnt, trip};
    endfunction : want
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic look(input logic [15:0] w);
        @(negedge CLK);
        chk(obs, w);
    endtask : look
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        PORT_WR <= 1'h1;
        PORT_ADDR <= a;
        PORT_WDATA <= d;
        @(posedge CLK);
        PORT_WR <= 1'h0;
        PORT_WDATA <= ~d;
        if (a == TIME_DIST_ENABLE_OFS) en_q = d;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge CLK);
        PORT_RD <= 1'h1;
        PORT_ADDR <= a;
        @(posedge CLK);
        PORT_RD <= 1'h0;
        @(negedge CLK);
        chk({8'h00, PORT_RDATA}, {8'h00, exp});
    endtask : rd
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge CLK);
            TICK <= 1'h1;
            @(posedge CLK);
            TICK <= 1'h0;
        end
    endtask : tick
    task automatic ka;
        @(posedge CLK);
        KEEPALIVE <= 1'h1;
        @(posedge CLK);
        KEEPALIVE <= 1'h0;
    endtask : ka
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    // Counts every tick and the time updates that should follow
    always @(posedge CLK) begin
        if (!SRST && TICK === 1'h1) begin
            tick_n = tick_n + 1;
            if (tick_n % 2048 == 0 && en_q != 8'h00) tu_exp = tu_exp + 16'h1;
        end
        if (!SRST && TIME_UPDATE === 1'h1) tu_seen = tu_seen + 16'h1;
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge CLK);
        SRST <= 1'h0;
        look(want(2'h1, 4'h0, 1'h0, 1'h0, 1'h0));
        rd(TIME_DIST_ENABLE_OFS, 8'hFF);
        rd(WDOG_LIMIT_LO_OFS, 8'hC0);
        rd(WDOG_LIMIT_HI_OFS, 8'h12);
        rd(WDOG_POLICY_OFS, 8'h00);
        i_bus.discretes(1'h0, 1'h1);
        i_bus.send(ASM_SLEEP, 1'h1);
        i_bus.send(ASM_HFR, 1'h1);
        wr(CONVERTER_POWER_OFS, 8'h01);
        look(want(2'h1, 4'h0, 1'h0, 1'h0, 1'h0));
        i_bus.discretes(1'h1, 1'h1);
        wr(CONVERTER_POWER_OFS, 8'h01);
        look(want(2'h1, 4'h0, 1'h0, 1'h1, 1'h0));
        i_bus.send(ASM_SLEEP, 1'h1);
        look(want(2'h0, 4'h0, 1'h0, 1'h1, 1'h0));
        i_bus.send(ASM_HFR, 1'h1);
        i_bus.send(ASM_ANALOG, 1'h1);
        wr(PROBE_POWER_OFS, 8'h01);
        i_bus.send(ASM_LPROBE, 1'h1);
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            wr(CONVERTER_POWER_OFS, {7'h00, rnd[0]});
            wr(PROBE_POWER_OFS, {7'h00, rnd[1]});
            look(want(2'h0, {3'h7, rnd[0]}, rnd[1], 1'h1, 1'h0));
        end
        wr(CONVERTER_POWER_OFS, 8'h01);
        wr(PROBE_POWER_OFS, 8'h01);
        i_bus.send(ASM_SLEEP, 1'h1);
        look(want(2'h0, 4'hF, 1'h1, 1'h1, 1'h0));
        i_bus.send(ASM_PAUSE, 1'h1);
        look(want(2'h3, 4'hF, 1'h1, 1'h1, 1'h0));
        tick(1);
        look(want(2'h3, 4'hF, 1'h1, 1'h1, 1'h0));
        tick(1);
        look(want(2'h0, 4'hF, 1'h1, 1'h1, 1'h0));
        i_bus.send(ASM_SLEEP, 1'h0);
        look(want(2'h1, 4'h0, 1'h0, 1'h1, 1'h0));
        i_bus.discretes(1'h0, 1'h1);
        look(want(2'h1, 4'h0, 1'h0, 1'h0, 1'h0));
        // Restrictive watchdog with a short random limit
        rnd = lfsr(rnd);
        lim = 8 + int'(rnd[4:0]);
        wr(WDOG_LIMIT_LO_OFS, 8'(lim));
        wr(WDOG_LIMIT_HI_OFS, 8'h00);
        wr(WDOG_POLICY_OFS, POLICY_KEEPALIVE);
        ka();
        repeat (4) begin
            tick(lim - 2);
            ka();
        end
        tick(lim - 1);
        @(posedge CLK);
        look(want(2'h1, 4'h0, 1'h0, 1'h0, 1'h0));
        tick(1);
        @(posedge CLK);
        look(want(2'h1, 4'h0, 1'h0, 1'h0, 1'h1));
        wr(WDOG_POLICY_OFS, POLICY_EVERY_TICK);
        // Time updates with the enable on, off, then random non-zero
        tick(2048);
        wr(TIME_DIST_ENABLE_OFS, 8'h00);
        tick(2048);
        rnd = lfsr(rnd);
        wr(TIME_DIST_ENABLE_OFS, {rnd[7:1], 1'h1});
        tick(2048);
        repeat (2) @(posedge CLK);
        chk(tu_seen, tu_exp);
        wrap_up();
    end
    // Hang guard well beyond the planned run length
    initial begin
        repeat (20000) @(posedge CLK);
        err_count++;
        wrap_up();
    end
endmodule : test_instrument_power_sleep_supervisor
